// >>> hdl/positioning_set_sequencer.sv
// positioning set sequencer: set store, start policy, target and motion setpoint
//
// Local design decisions: the address map and the APB register port.
`timescale 1ns/1ns
// Notes on behaviour
// - 64 sets, four groups of sixteen starting at 0, 16, 32, 48.
// - sixteen option: only sets 0..15, each with its own profile.
// - mode shared per group, threshold shared by all, destination per set.
// - absolute: destination is the position from the home point.
// - relative: destination added to present setpoint, even while moving.
// - relative to last: destination added to the last or current target.
// - relative with wait policy: new target refers to previous target.
// - relative with interrupt: new target from setpoint at acceptance.
// - wait: start during run latches set, runs it after completion.
// - interrupt: start during run aborts and heads for the new target.
// - ignore: no selection or start accepted until run completes.
// - remaining distance flag rises at one threshold shared by all sets.
// - accepted start waits the start delay before motion begins.
// - run travels at running speed and always ends at zero speed.
// - reported ramp times derive from running speed and rates.
// - acceleration passes a jerk filter; zero constant is time optimal.
// - general setpoint ramp has no effect while homing or positioning.
// - six select inputs choose the positioning set.
// - start rising edge captures the set; selects settle beforehand.
// - course program runs from one of two start lines.
// - status shows target reached, remaining distance reached, homed.
module positioning_set_sequencer
  import possets_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  apb_req_t        apb_req,
  output apb_rsp_t        apb_rsp,
  input  wire logic       set_select_bit_lsb,
  input  wire logic [3:0] set_select_bits_mid,
  input  wire logic       set_select_bit_msb,
  input  wire logic       positioning_start_input,
  input  wire logic       homing_active,
  input  wire logic       homing_done,
  output pos_status_t     status,
  output logic [31:0]     position_setpoint
);
  typedef enum logic [3:0] {R_NONE, R_CTRL, R_STATUS, R_REMAIN, R_LINE0, R_LINE1, R_POS,
                            R_TARGET, R_TIMES, R_RAMP, R_MANUAL, R_PROF, R_DEST} reg_sel_t;

  typedef struct packed {
    logic        pos_en;
    logic        sixteen;
    logic        course;
    logic        line_sel;
    logic [31:0] remain_thr;
    logic [5:0]  line0;
    logic [5:0]  line1;
    logic [15:0] ramp;
    logic [15:0] man_speed;
    logic        man_dir;
    run_state_t  state;
    logic [23:0] tick_cnt;
    logic [15:0] delay_cnt;
    logic [31:0] pos;
    logic [31:0] target;
    logic [15:0] vel;
    logic signed [17:0] acc_f;
    logic [5:0]  cur_set;
    logic        pend_v;
    logic [5:0]  pend_set;
    logic        reached;
    logic        remain_hit;
    logic        homed;
    logic        st1;
    logic        st2;
    logic        st3;
    logic [31:0] prdata;
    logic        slverr;
  } st_t;

  st_t         s_r;
  st_t         s_nxt;
  profile_t    prof_mem [NUM_PROF];
  logic [31:0] dest_mem [NUM_SETS];

  function automatic logic [3:0] prof_idx(input logic [5:0] set, input logic sixteen);
    prof_idx = sixteen ? set[3:0] : {2'b00, set[5:4]};
  endfunction

  function automatic logic [3:0] prof_slot(input logic [11:0] a);
    logic [11:0] off;
    off       = a - A_PROF_BASE;
    prof_slot = off[PROF_SHIFT+3:PROF_SHIFT];
  endfunction

  function automatic reg_sel_t decode(input logic [11:0] a);
    decode = R_NONE;
    if (a[1:0] == 2'b00) begin
      case (a)
        A_CTRL:   decode = R_CTRL;
        A_STATUS: decode = R_STATUS;
        A_REMAIN: decode = R_REMAIN;
        A_LINE0:  decode = R_LINE0;
        A_LINE1:  decode = R_LINE1;
        A_POS:    decode = R_POS;
        A_TARGET: decode = R_TARGET;
        A_TIMES:  decode = R_TIMES;
        A_RAMP:   decode = R_RAMP;
        A_MANUAL: decode = R_MANUAL;
        default: begin
          if (a >= A_PROF_BASE && a <= A_PROF_END && a[4:2] <= PW_DELAY) begin
            decode = R_PROF;
          end else if (a >= A_DEST_BASE && a <= A_DEST_END) begin
            decode = R_DEST;
          end
        end
      endcase
    end
  endfunction

  function automatic logic [31:0] calc_target(input profile_t p, input logic [31:0] dest,
                                              input logic [31:0] pos, input logic [31:0] last,
                                              input logic chained);
    case (p.mode)
      MODE_ABS:      calc_target = dest;
      MODE_REL_LAST: calc_target = last + dest;
      default:       calc_target = chained ? last + dest : pos + dest;
    endcase
  endfunction

  logic [5:0]         sel_pins;
  logic [5:0]         chosen;
  logic [5:0]         eff_set;
  logic               start_ev;
  logic               busy;
  logic               chain_go;
  logic               accept;
  logic               latch;
  logic [5:0]         accept_set;
  profile_t           run_prof;
  profile_t           acc_prof;
  logic [31:0]        new_target;
  logic               tick;
  logic signed [32:0] diff;
  logic [31:0]        rem;
  logic               dir;
  logic [15:0]        m_vel;
  logic signed [17:0] m_acc;
  logic [15:0]        accel_time;
  logic [15:0]        decel_time;
  reg_sel_t           rd_sel;
  reg_sel_t           wr_sel;
  logic               wr_en;
  logic [31:0]        rd_val;

  assign sel_pins   = {set_select_bit_msb, set_select_bits_mid, set_select_bit_lsb};
  assign chosen     = s_r.course ? (s_r.line_sel ? s_r.line1 : s_r.line0) : sel_pins;
  assign eff_set    = s_r.sixteen ? {2'b00, chosen[3:0]} : chosen;
  assign start_ev   = s_r.st2 & ~s_r.st3;
  assign busy       = (s_r.state != ST_IDLE);
  assign run_prof   = prof_mem[prof_idx(s_r.cur_set, s_r.sixteen)];
  assign chain_go   = s_r.pos_en && !busy && s_r.pend_v;
  // policy of the run in progress decides what a start during it does
  assign accept     = s_r.pos_en && (chain_go || (start_ev && (!busy ||
                      run_prof.pol == POL_INTERRUPT)));
  assign latch      = s_r.pos_en && start_ev && (chain_go || (busy &&
                      run_prof.pol == POL_WAIT));
  assign accept_set = chain_go ? s_r.pend_set : eff_set;
  assign acc_prof   = prof_mem[prof_idx(accept_set, s_r.sixteen)];
  assign new_target = calc_target(acc_prof, dest_mem[accept_set], s_r.pos, s_r.target, chain_go);
  assign tick       = (s_r.tick_cnt == 24'(TICK_LEN - 1));
  assign diff       = $signed({s_r.target[31], s_r.target}) - $signed({s_r.pos[31], s_r.pos});
  assign dir        = diff[32];
  assign rem        = dir ? 32'(-diff) : diff[31:0];
  assign rd_sel     = decode(apb_req.paddr);
  assign wr_sel     = rd_sel;
  assign wr_en      = apb_req.psel & apb_req.penable & apb_req.pwrite;

  motion_step u_step (
    .prof       (run_prof),
    .vel        (s_r.vel),
    .acc_f      (s_r.acc_f),
    .rem        (rem),
    .vel_nxt    (m_vel),
    .acc_f_nxt  (m_acc),
    .accel_time (accel_time),
    .decel_time (decel_time)
  );

  always_comb begin
    profile_t rp;
    rp     = prof_mem[prof_slot(apb_req.paddr)];
    rd_val = 32'h0000_0000;
    case (rd_sel)
      R_CTRL:   rd_val = 32'({s_r.line_sel, s_r.course, s_r.sixteen, s_r.pos_en});
      R_STATUS: rd_val = {18'h00000, s_r.cur_set, 1'b0, s_r.state, s_r.pend_v, busy, s_r.homed,
                          s_r.remain_hit, s_r.reached};
      R_REMAIN: rd_val = s_r.remain_thr;
      R_LINE0:  rd_val = 32'(s_r.line0);
      R_LINE1:  rd_val = 32'(s_r.line1);
      R_POS:    rd_val = s_r.pos;
      R_TARGET: rd_val = s_r.target;
      R_TIMES:  rd_val = {decel_time, accel_time};
      R_RAMP:   rd_val = 32'(s_r.ramp);
      R_MANUAL: rd_val = {15'h0000, s_r.man_dir, s_r.man_speed};
      R_PROF: begin
        case (apb_req.paddr[4:2])
          PW_CFG:   rd_val = 32'({rp.pol, rp.mode});
          PW_SPEED: rd_val = 32'(rp.speed);
          PW_ACCEL: rd_val = 32'(rp.accel);
          PW_DECEL: rd_val = 32'(rp.decel);
          PW_JERK:  rd_val = 32'(rp.jerk_sh);
          default:  rd_val = 32'(rp.delay);
        endcase
      end
      R_DEST:   rd_val = dest_mem[apb_req.paddr[7:2]];
      default:  rd_val = 32'h0000_0000;
    endcase
  end

  always_comb begin
    s_nxt     = s_r;
    s_nxt.st1 = positioning_start_input;
    s_nxt.st2 = s_r.st1;
    s_nxt.st3 = s_r.st2;
    s_nxt.tick_cnt = tick ? 24'h000000 : s_r.tick_cnt + 24'h000001;
    if (apb_req.psel && !apb_req.penable) begin
      s_nxt.prdata = rd_val;
      s_nxt.slverr = (rd_sel == R_NONE);
    end
    if (wr_en) begin
      case (wr_sel)
        R_CTRL: begin
          s_nxt.pos_en   = apb_req.pwdata[CTRL_POS_EN];
          s_nxt.sixteen  = apb_req.pwdata[CTRL_SIXTEEN];
          s_nxt.course   = apb_req.pwdata[CTRL_COURSE];
          s_nxt.line_sel = apb_req.pwdata[CTRL_LINE_SEL];
          if (apb_req.pwdata[CTRL_HOMED_CLR]) begin
            s_nxt.homed = 1'b0;
          end
        end
        R_REMAIN: s_nxt.remain_thr = apb_req.pwdata;
        R_LINE0:  s_nxt.line0 = apb_req.pwdata[5:0];
        R_LINE1:  s_nxt.line1 = apb_req.pwdata[5:0];
        R_RAMP:   s_nxt.ramp = apb_req.pwdata[15:0];
        R_MANUAL: begin
          s_nxt.man_speed = apb_req.pwdata[15:0];
          s_nxt.man_dir   = apb_req.pwdata[MANUAL_DIR];
        end
        default: begin
        end
      endcase
    end
    // hardware set wins over the software clear
    if (homing_done) begin
      s_nxt.homed = 1'b1;
    end
    if (!s_r.pos_en) begin
      s_nxt.state  = ST_IDLE;
      s_nxt.pend_v = 1'b0;
      if (!homing_active && tick) begin
        // general ramp only acts outside positioning and homing
        if (s_r.vel < s_r.man_speed) begin
          s_nxt.vel = (s_r.man_speed - s_r.vel > s_r.ramp) ? s_r.vel + s_r.ramp
                                                           : s_r.man_speed;
        end else begin
          s_nxt.vel = (s_r.vel - s_r.man_speed > s_r.ramp) ? s_r.vel - s_r.ramp
                                                           : s_r.man_speed;
        end
        s_nxt.pos    = s_r.man_dir ? s_r.pos - 32'(s_r.vel) : s_r.pos + 32'(s_r.vel);
        s_nxt.target = s_nxt.pos;
      end
    end else if (accept) begin
      s_nxt.target     = new_target;
      s_nxt.cur_set    = accept_set;
      s_nxt.pend_v     = 1'b0;
      s_nxt.reached    = 1'b0;
      s_nxt.remain_hit = 1'b0;
      s_nxt.vel        = 16'h0000;
      s_nxt.acc_f      = 18'sh00000;
      s_nxt.tick_cnt   = 24'h000000;
      s_nxt.delay_cnt  = acc_prof.delay;
      s_nxt.state      = (acc_prof.delay == 16'h0000) ? ST_RUN : ST_DELAY;
    end else begin
      case (s_r.state)
        ST_DELAY: begin
          if (tick) begin
            s_nxt.delay_cnt = s_r.delay_cnt - 16'h0001;
            if (s_r.delay_cnt <= 16'h0001) begin
              s_nxt.state = ST_RUN;
            end
          end
        end
        ST_RUN: begin
          if (rem <= s_r.remain_thr) begin
            s_nxt.remain_hit = 1'b1;
          end
          if (tick) begin
            if (32'(m_vel) >= rem) begin
              s_nxt.pos     = s_r.target;
              s_nxt.vel     = 16'h0000;
              s_nxt.acc_f   = 18'sh00000;
              s_nxt.reached = 1'b1;
              s_nxt.state   = ST_IDLE;
            end else begin
              s_nxt.pos   = dir ? s_r.pos - 32'(m_vel) : s_r.pos + 32'(m_vel);
              s_nxt.vel   = m_vel;
              s_nxt.acc_f = m_acc;
            end
          end
        end
        default: begin
        end
      endcase
    end
    if (latch) begin
      s_nxt.pend_v   = 1'b1;
      s_nxt.pend_set = eff_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r            <= '0;
      s_r.state      <= ST_IDLE;
      s_r.remain_thr <= RST_REMAIN;
      s_r.ramp       <= RST_RAMP;
    end else begin
      s_r <= s_nxt;
    end
  end

  // set store: whole profiles per group or per set, destination per set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_PROF; i++) begin
        prof_mem[i] <= PROF_RESET;
      end
      for (int i = 0; i < NUM_SETS; i++) begin
        dest_mem[i] <= RST_DEST;
      end
    end else if (wr_en && wr_sel == R_DEST) begin
      dest_mem[apb_req.paddr[7:2]] <= apb_req.pwdata;
    end else if (wr_en && wr_sel == R_PROF) begin
      case (apb_req.paddr[4:2])
        PW_CFG: begin
          prof_mem[prof_slot(apb_req.paddr)].mode <= tgt_mode_t'(apb_req.pwdata[1:0]);
          prof_mem[prof_slot(apb_req.paddr)].pol  <= start_pol_t'(apb_req.pwdata[3:2]);
        end
        PW_SPEED: prof_mem[prof_slot(apb_req.paddr)].speed   <= apb_req.pwdata[15:0];
        PW_ACCEL: prof_mem[prof_slot(apb_req.paddr)].accel   <= apb_req.pwdata[15:0];
        PW_DECEL: prof_mem[prof_slot(apb_req.paddr)].decel   <= apb_req.pwdata[15:0];
        PW_JERK:  prof_mem[prof_slot(apb_req.paddr)].jerk_sh <= apb_req.pwdata[3:0];
        default:  prof_mem[prof_slot(apb_req.paddr)].delay   <= apb_req.pwdata[15:0];
      endcase
    end
  end

  assign apb_rsp.prdata          = s_r.prdata;
  assign apb_rsp.pready          = 1'b1;
  assign apb_rsp.pslverr         = s_r.slverr;
  assign status.target_reached   = s_r.reached;
  assign status.remain_reached   = s_r.remain_hit;
  assign status.homing_performed = s_r.homed;
  assign status.run_active       = busy;
  assign position_setpoint       = s_r.pos;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ignore_holds_run: assert property (busy && start_ev && run_prof.pol == POL_IGNORE &&
    !chain_go |=> $stable(s_r.target) && $stable(s_r.cur_set) && !s_r.pend_v)
    else $error("start accepted under ignore policy");
  a_wait_latches_set: assert property (s_r.pos_en && busy && start_ev &&
    run_prof.pol == POL_WAIT |=> s_r.pend_v && s_r.pend_set == $past(eff_set))
    else $error("wait policy did not latch the set");
  a_chain_follows: assert property (chain_go && !start_ev |=> busy &&
    s_r.cur_set == $past(s_r.pend_set) && !s_r.pend_v)
    else $error("latched run did not start");
  a_interrupt_retarget: assert property (s_r.pos_en && s_r.state == ST_RUN && start_ev &&
    run_prof.pol == POL_INTERRUPT |=> s_r.cur_set == $past(eff_set) && s_r.vel == 16'h0000)
    else $error("interrupt did not take the new set");
  a_done_at_rest: assert property ($rose(s_r.reached) |-> s_r.vel == 16'h0000 &&
    s_r.pos == s_r.target && s_r.state == ST_IDLE)
    else $error("run ended away from target or moving");
  a_abs_target: assert property (accept && acc_prof.mode == MODE_ABS |=>
    s_r.target == $past(dest_mem[accept_set]))
    else $error("absolute target differs from destination");
  a_delay_no_motion: assert property (s_r.state == ST_DELAY && s_r.pos_en && !accept |=>
    $stable(s_r.pos))
    else $error("motion during start delay");
  a_remain_flag: assert property (s_r.pos_en && s_r.state == ST_RUN && !accept &&
    rem <= s_r.remain_thr |=> s_r.remain_hit)
    else $error("remaining distance flag missed");
  a_sixteen_limit: assert property (s_r.sixteen && accept && !chain_go |=>
    s_r.cur_set[5:4] == 2'b00)
    else $error("set above fifteen with sixteen option");
  a_one_event: assert property (start_ev |=> !start_ev)
    else $error("one edge gave two start events");
  a_start_lag: assert property ($rose(positioning_start_input) |-> ##2 start_ev)
    else $error("start edge not seen two cycles later");

  c_interrupt: cover property (busy && start_ev && run_prof.pol == POL_INTERRUPT);
  c_wait_chain: cover property (chain_go);
  c_ignore: cover property (busy && start_ev && run_prof.pol == POL_IGNORE);
  c_rel_done: cover property ($rose(s_r.reached) && run_prof.mode == MODE_REL);
endmodule // positioning_set_sequencer

// >>> hdl/possets_pkg.sv
// shared constants and types of the positioning set sequencer
package possets_pkg;
  localparam int CLK_HZ      = 20_000_000;
  localparam int TICK_US     = 1000;
  localparam int TICK_CYCLES = (CLK_HZ / 1_000_000) * TICK_US;
  localparam int NUM_SETS    = 64;
  localparam int NUM_PROF    = 16;

  localparam logic [11:0] A_CTRL      = 12'h000;
  localparam logic [11:0] A_STATUS    = 12'h004;
  localparam logic [11:0] A_REMAIN    = 12'h008;
  localparam logic [11:0] A_LINE0     = 12'h00c;
  localparam logic [11:0] A_LINE1     = 12'h010;
  localparam logic [11:0] A_POS       = 12'h014;
  localparam logic [11:0] A_TARGET    = 12'h018;
  localparam logic [11:0] A_TIMES     = 12'h01c;
  localparam logic [11:0] A_RAMP      = 12'h020;
  localparam logic [11:0] A_MANUAL    = 12'h024;
  localparam logic [11:0] A_PROF_BASE = 12'h100;
  localparam logic [11:0] A_PROF_END  = 12'h2ff;
  localparam logic [11:0] A_DEST_BASE = 12'h400;
  localparam logic [11:0] A_DEST_END  = 12'h4ff;
  localparam int          PROF_SHIFT  = 5;

  localparam logic [2:0] PW_CFG   = 3'h0;
  localparam logic [2:0] PW_SPEED = 3'h1;
  localparam logic [2:0] PW_ACCEL = 3'h2;
  localparam logic [2:0] PW_DECEL = 3'h3;
  localparam logic [2:0] PW_JERK  = 3'h4;
  localparam logic [2:0] PW_DELAY = 3'h5;

  localparam int CTRL_POS_EN    = 0;
  localparam int CTRL_SIXTEEN   = 1;
  localparam int CTRL_COURSE    = 2;
  localparam int CTRL_LINE_SEL  = 3;
  localparam int CTRL_HOMED_CLR = 8;
  localparam int MANUAL_DIR     = 16;
  localparam int ST_CUR_SET     = 8;

  localparam logic [15:0] MIN_RATE   = 16'h0001;
  localparam logic [31:0] RST_REMAIN = 32'h0000_0000;
  localparam logic [31:0] RST_DEST   = 32'h0000_0000;
  localparam logic [15:0] RST_RAMP   = 16'h0001;

  typedef enum logic [1:0] {MODE_ABS, MODE_REL, MODE_REL_LAST} tgt_mode_t;
  typedef enum logic [1:0] {POL_IGNORE, POL_WAIT, POL_INTERRUPT} start_pol_t;
  typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_RUN} run_state_t;

  typedef struct packed {
    start_pol_t  pol;
    tgt_mode_t   mode;
    logic [15:0] speed;
    logic [15:0] accel;
    logic [15:0] decel;
    logic [3:0]  jerk_sh;
    logic [15:0] delay;
  } profile_t;

  localparam profile_t PROF_RESET = '{pol: POL_IGNORE, mode: MODE_ABS, speed: 16'h0064,
                                      accel: 16'h000a, decel: 16'h000a, jerk_sh: 4'h0,
                                      delay: 16'h0000};

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_t;

  typedef struct packed {
    logic target_reached;
    logic remain_reached;
    logic homing_performed;
    logic run_active;
  } pos_status_t;
endpackage

// >>> hdl/motion_step.sv
// one motion tick of a profile: speed ramp, jerk filter and ramp durations
`timescale 1ns/1ns
module motion_step
  import possets_pkg::*;
(
  input  profile_t                prof,
  input  wire logic [15:0]        vel,
  input  wire logic signed [17:0] acc_f,
  input  wire logic [31:0]        rem,
  output logic [15:0]             vel_nxt,
  output logic signed [17:0]      acc_f_nxt,
  output logic [15:0]             accel_time,
  output logic [15:0]             decel_time
);
  logic [15:0]        acc_rate;
  logic [15:0]        dec_rate;
  logic signed [17:0] acc_s;
  logic signed [17:0] dec_s;
  logic [31:0]        vv;
  logic [48:0]        stop_dist;
  logic signed [17:0] cmd;
  logic signed [17:0] diff;
  logic signed [18:0] vsum;

  always_comb begin
    // zero rates would stall the run or divide by zero
    acc_rate  = (prof.accel == 16'h0000) ? MIN_RATE : prof.accel;
    dec_rate  = (prof.decel == 16'h0000) ? MIN_RATE : prof.decel;
    acc_s     = $signed({2'b00, acc_rate});
    dec_s     = $signed({2'b00, dec_rate});
    vv        = 32'(vel) * 32'(vel);
    stop_dist = 49'(rem) * 49'({dec_rate, 1'b0});
    if (vel != 16'h0000 && 49'(vv) >= stop_dist) begin
      cmd = -dec_s;
    end else if (vel < prof.speed) begin
      cmd = acc_s;
    end else if (vel > prof.speed) begin
      cmd = -dec_s;
    end else begin
      cmd = 18'sh00000;
    end
    diff      = cmd - acc_f;
    acc_f_nxt = (prof.jerk_sh == 4'h0) ? cmd : acc_f + (diff >>> prof.jerk_sh);
    vsum      = $signed({3'b000, vel}) + $signed({acc_f_nxt[17], acc_f_nxt});
    // speed never drops to zero mid run, so a run always closes on its target
    if (vsum < 19'sh00001) begin
      vel_nxt = 16'h0001;
    end else if (vsum > 19'sh0ffff) begin
      vel_nxt = 16'hffff;
    end else begin
      vel_nxt = vsum[15:0];
    end
    accel_time = prof.speed / acc_rate;
    decel_time = prof.speed / dec_rate;
  end
endmodule // motion_step

// >>> tb/pos_ctl_model.sv
// partner controller: drives the set selects and the start edge
`timescale 1ns/1ns
module pos_ctl_model (
  input  wire logic  pclk,
  output logic       sel_lsb,
  output logic [3:0] sel_mid,
  output logic       sel_msb,
  output logic       start
);
  initial begin
    {sel_msb, sel_mid, sel_lsb} = 6'h00;
    start = 1'b0;
  end
  // selects settle before the edge; one clean edge, no bounce
  task automatic launch(input logic [5:0] s);
    @(posedge pclk);
    {sel_msb, sel_mid, sel_lsb} <= s;
    repeat (3) @(posedge pclk);
    start <= 1'b1;
    repeat (5) @(posedge pclk);
    start <= 1'b0;
    // stale selects must not leak into the captured set
    {sel_msb, sel_mid, sel_lsb} <= ~s;
  endtask
endmodule // pos_ctl_model

// >>> tb/positioning_set_sequencer_tb.sv
// self-checking bench of the positioning set sequencer
`timescale 1ns/1ns
module positioning_set_sequencer_tb import possets_pkg::*;;
  logic        pclk        = 1'b0;
  logic        presetn     = 1'b0;
  logic        homing_done = 1'b0;
  apb_req_t    req         = '0;
  apb_rsp_t    rsp;
  pos_status_t status;
  logic        s_lsb, s_msb, start;
  logic [3:0]  s_mid;
  logic [31:0] pos_sp;
  logic [32:0] expq[$];
  logic [32:0] exp_v;
  logic [7:0]  rnd         = 8'h21;
  int          n_mismatch  = 0;
  int          checks_done = 0;
  int          cyc         = 0;

  always #25 pclk = ~pclk;

  positioning_set_sequencer #(.TICK_LEN(4)) i_dut (.pclk(pclk), .presetn(presetn),
    .apb_req(req), .apb_rsp(rsp), .set_select_bit_lsb(s_lsb), .set_select_bits_mid(s_mid),
    .set_select_bit_msb(s_msb), .positioning_start_input(start), .homing_active(1'b0),
    .homing_done(homing_done), .status(status), .position_setpoint(pos_sp));
  pos_ctl_model i_ctl (.pclk(pclk), .sel_lsb(s_lsb), .sel_mid(s_mid), .sel_msb(s_msb),
    .start(start));

  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] s);
    checks_done++;
    if (s !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic tally_and_finish();
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // reads note {pslverr, prdata} for the monitor; no fixed wait count assumed
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    @(posedge pclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    if (!wr) expq.push_back(e);
    @(posedge pclk);
    req.penable <= 1'b1;
    // this wait ends once pready is seen high, else at the bench timeout
    do begin
      @(posedge pclk);
    end while (rsp.pready !== 1'b1);
    req <= '0;
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (status.run_active !== 1'b0 && n < 4000);
    chk("run_active", 33'h0, {32'h0, status.run_active});
  endtask

  always @(posedge pclk) begin
    if (req.psel && req.penable && !req.pwrite && rsp.pready === 1'b1) begin
      exp_v = (expq.size() > 0) ? expq.pop_front() : 'x;
      chk("apb read", exp_v, {rsp.pslverr, rsp.prdata});
    end
  end

  // whole run needs a few hundred cycles
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, A_STATUS, 32'h0, 33'h0);
    apb(1'b0, 12'h300, 32'h0, 33'h1_0000_0000);
    apb(1'b1, A_CTRL, 32'h1, 33'h0);
    rnd = lfsr(rnd);
    apb(1'b1, A_DEST_BASE + 12'h014, {24'h0, rnd}, 33'h0);
    i_ctl.launch(6'h05);
    wait_idle();
    chk("target_reached", 33'h1, {32'h0, status.target_reached});
    apb(1'b0, A_POS, 32'h0, {25'h0, rnd});
    apb(1'b1, A_PROF_BASE + 12'h060, 32'h1, 33'h0);
    apb(1'b1, A_DEST_BASE + 12'h0c4, 32'h7, 33'h0);
    i_ctl.launch(6'h31);
    wait_idle();
    apb(1'b0, A_POS, 32'h0, {25'h0, rnd} + 33'h7);
    apb(1'b1, A_CTRL, 32'h3, 33'h0);
    apb(1'b1, A_DEST_BASE + 12'h004, 32'h3, 33'h0);
    i_ctl.launch(6'h31);
    wait_idle();
    apb(1'b0, A_TARGET, 32'h0, 33'h3);
    homing_done <= 1'b1;
    @(posedge pclk);
    homing_done <= 1'b0;
    @(posedge pclk);
    #1;
    chk("homing_performed", 33'h1, {32'h0, status.homing_performed});
    // wait policy: second start mid run is latched, then chained on the first target
    apb(1'b1, A_CTRL, 32'h1, 33'h0);
    apb(1'b1, A_REMAIN, 32'h100, 33'h0);
    apb(1'b1, A_PROF_BASE + 12'h040, 32'h5, 33'h0);
    apb(1'b1, A_PROF_BASE + 12'h054, 32'h2, 33'h0);
    rnd = lfsr(rnd);
    apb(1'b1, A_DEST_BASE + 12'h080, {24'h0, rnd}, 33'h0);
    apb(1'b1, A_DEST_BASE + 12'h084, 32'h5, 33'h0);
    i_ctl.launch(6'h20);
    i_ctl.launch(6'h21);
    // the chain leaves one idle cycle between the two runs
    wait_idle();
    wait_idle();
    chk("remain_reached", 33'h1, {32'h0, status.remain_reached});
    apb(1'b0, A_TARGET, 32'h0, {25'h0, rnd} + 33'h8);
    chk("position_setpoint", {25'h0, rnd} + 33'h8, {1'b0, pos_sp});
    tally_and_finish();
  end
endmodule // positioning_set_sequencer_tb
